// [timer_pkg.sv]
/*
  Package for the dual timer/counter: register indices, field positions,
  mode codes and tick divisors.
  Assumes a 32-bit AHB-Lite register bus; byte address is four times the index.
*/
package timer_pkg;
  // Register indices (byte address = index * 4)
  localparam logic [7:0] IDX_RUN_FLAGS = 8'h88;
  localparam logic [7:0] IDX_MODE = 8'h89;
  localparam logic [7:0] IDX_ZERO_LOW = 8'h8A;
  localparam logic [7:0] IDX_ONE_LOW = 8'h8B;
  localparam logic [7:0] IDX_ZERO_HIGH = 8'h8C;
  localparam logic [7:0] IDX_ONE_HIGH = 8'h8D;
  localparam logic [7:0] IDX_TICK_SEL = 8'h8E;
  // Mode register fields: unit one in the upper nibble, unit zero in the lower
  localparam int ONE_GATE_BIT = 7;
  localparam int ONE_CT_BIT = 6;
  localparam int ONE_MODE_LSB = 4;
  localparam int ZERO_GATE_BIT = 3;
  localparam int ZERO_CT_BIT = 2;
  localparam int ZERO_MODE_LSB = 0;
  // Tick select fields
  localparam int ONE_TICK_BIT = 4;
  localparam int ZERO_TICK_BIT = 3;
  // Run and flag register fields
  localparam int ONE_FLAG_BIT = 7;
  localparam int ONE_RUN_BIT = 6;
  localparam int ZERO_FLAG_BIT = 5;
  localparam int ZERO_RUN_BIT = 4;
  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Mode codes
  localparam logic [1:0] MODE_PRESCALE = 2'h0;
  localparam logic [1:0] MODE_WIDE = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  // Prescaler width in the 13-bit mode
  localparam int PRESCALE_BITS = 5;
  // Internal tick divisors
  localparam int DIV_SLOW = 12;
  localparam int DIV_FAST = 4;
  // AHB transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;
endpackage

// [tick_if.sv]
/*
  Interface carrying the two internal tick enables from the divider.
  Assumes both ends run on hclk.
*/
`timescale 1ns/100ps
interface tick_if;
  logic tick_slow;
  logic tick_fast;
  modport src (output tick_slow, output tick_fast);
  modport snk (input tick_slow, input tick_fast);
endinterface

// [tick_divider.sv]
/*
  Divider producing one-cycle tick enables at hclk/DIV_SLOW and hclk/DIV_FAST.
  Assumes a single clock hclk with asynchronous active-low reset.
*/
`timescale 1ns/100ps
module tick_divider
  import timer_pkg::*;
#(
  parameter int SLOW = DIV_SLOW,
  parameter int FAST = DIV_FAST
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Tick enables
  tick_if.src ticks
);
  logic [7:0] slow_cnt_r;
  logic [7:0] fast_cnt_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_cnt_r <= 8'h00;
      ticks.tick_slow <= 1'b0;
    end else if (slow_cnt_r == 8'(SLOW - 1)) begin
      slow_cnt_r <= 8'h00;
      ticks.tick_slow <= 1'b1;
    end else begin
      slow_cnt_r <= slow_cnt_r + 8'h01;
      ticks.tick_slow <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_cnt_r <= 8'h00;
      ticks.tick_fast <= 1'b0;
    end else if (fast_cnt_r == 8'(FAST - 1)) begin
      fast_cnt_r <= 8'h00;
      ticks.tick_fast <= 1'b1;
    end else begin
      fast_cnt_r <= fast_cnt_r + 8'h01;
      ticks.tick_fast <= 1'b0;
    end
  end
endmodule

// [pin_sync.sv]
/*
  Two-flop synchroniser with falling-edge detector for one pin.
  Assumes the pin is asynchronous to hclk.
*/
`timescale 1ns/100ps
module pin_sync (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pin and results
  input wire logic pin,
  output logic level,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  // One event per high-to-low transition
  assign fall = prev_r & ~sync_r;
endmodule

// [dual_timer_counter.sv]
/*
  Dual timer/counter with AHB-Lite register slave.
  Assumes one master, single word transfers, and same-clock service acknowledges.
*/
`timescale 1ns/100ps
module dual_timer_counter
  import timer_pkg::*;
(
  // AHB-Lite
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // External pins
  input wire logic unit_zero_count_pin,
  input wire logic unit_one_count_pin,
  input wire logic ext_irq_zero_pin,
  input wire logic ext_irq_one_pin,
  // Service entry acknowledges
  input wire logic isr_ack_zero,
  input wire logic isr_ack_one,
  // Overflow flags
  output logic unit_zero_overflow_flag,
  output logic unit_one_overflow_flag
);
  logic [7:0] timer_mode_control_r;
  logic [7:0] timer_zero_low_byte_r;
  logic [7:0] timer_zero_high_byte_r;
  logic [7:0] timer_one_low_byte_r;
  logic [7:0] timer_one_high_byte_r;
  logic unit_zero_tick_select_r;
  logic unit_one_tick_select_r;
  logic unit_zero_run_r;
  logic unit_one_run_r;
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic [7:0] rd_nxt;
  logic addr_ok;
  logic cnt0_fall;
  logic cnt1_fall;
  logic gate0_lvl;
  logic gate1_lvl;
  logic [1:0] mode_zero;
  logic [1:0] mode_one;
  logic en0;
  logic en1;
  logic inc0;
  logic inc1;
  logic split_inc;
  logic split;
  logic [16:0] step0;
  logic [16:0] step1;
  logic [8:0] split_low;
  logic [8:0] split_high;
  logic ov0;
  logic ov1;
  logic wr_ctl;
  logic [7:0] wdat;

  // Both ticks run free from reset release; each unit only picks one
  tick_if ticks ();

  tick_divider #(.SLOW(DIV_SLOW), .FAST(DIV_FAST)) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .ticks(ticks)
  );

  // Every pin is asynchronous to hclk, so each passes two flops first
  pin_sync u_cnt0 (.hclk(hclk), .hresetn(hresetn), .pin(unit_zero_count_pin),
    .level(), .fall(cnt0_fall));
  pin_sync u_cnt1 (.hclk(hclk), .hresetn(hresetn), .pin(unit_one_count_pin),
    .level(), .fall(cnt1_fall));
  pin_sync u_gate0 (.hclk(hclk), .hresetn(hresetn), .pin(ext_irq_zero_pin),
    .level(gate0_lvl), .fall());
  pin_sync u_gate1 (.hclk(hclk), .hresetn(hresetn), .pin(ext_irq_one_pin),
    .level(gate1_lvl), .fall());

  // One step of a unit in modes 00 to 10; returns {overflow, high, low}
  function automatic logic [16:0] unit_step(input logic [1:0] m, input logic [7:0] lo,
                                            input logic [7:0] hi, input logic inc);
    logic [16:0] r;
    logic [8:0] s;
    logic [PRESCALE_BITS:0] p;
    r = {1'b0, hi, lo};
    s = 9'h000;
    p = '0;
    if (inc) begin
      case (m)
        MODE_PRESCALE: begin
          // Upper low-byte bits are left alone
          p = {1'b0, lo[PRESCALE_BITS-1:0]} + 1'b1;
          s = p[PRESCALE_BITS] ? {1'b0, hi} + 9'h001 : {1'b0, hi};
          r = {s[8], s[7:0], lo[7:PRESCALE_BITS], p[PRESCALE_BITS-1:0]};
        end
        MODE_WIDE: begin
          r = {1'b0, hi, lo} + 17'h00001;
        end
        MODE_RELOAD: begin
          s = {1'b0, lo} + 9'h001;
          r = {s[8], hi, s[8] ? hi : s[7:0]};
        end
        default: begin
          r = {1'b0, hi, lo};
        end
      endcase
    end
    return r;
  endfunction

  // Counting control
  assign mode_zero = timer_mode_control_r[ZERO_MODE_LSB +: 2];
  assign mode_one = timer_mode_control_r[ONE_MODE_LSB +: 2];
  // Split mode lends unit zero's high byte to unit one's run bit and tick
  assign split = (mode_zero == MODE_SPLIT);
  // A gated unit waits for its irq pin level as well as its run bit
  assign en0 = unit_zero_run_r & (~timer_mode_control_r[ZERO_GATE_BIT] | gate0_lvl);
  assign en1 = unit_one_run_r & (~timer_mode_control_r[ONE_GATE_BIT] | gate1_lvl);
  // Ticks are picked per unit so the two units may run at different rates
  assign inc0 = en0 & (timer_mode_control_r[ZERO_CT_BIT] ? cnt0_fall :
    (unit_zero_tick_select_r ? ticks.tick_fast : ticks.tick_slow));
  assign inc1 = en1 & (timer_mode_control_r[ONE_CT_BIT] ? cnt1_fall :
    (unit_one_tick_select_r ? ticks.tick_fast : ticks.tick_slow));
  // Split high timer: internal tick only, unit one run bit only
  assign split_inc = unit_one_run_r &
    (unit_one_tick_select_r ? ticks.tick_fast : ticks.tick_slow);

  // Unit one is masked in mode 11 so it holds instead of wrapping
  assign step0 = unit_step(mode_zero, timer_zero_low_byte_r, timer_zero_high_byte_r, inc0);
  assign step1 = unit_step(mode_one, timer_one_low_byte_r, timer_one_high_byte_r,
    inc1 & (mode_one != MODE_SPLIT));
  assign split_low = {1'b0, timer_zero_low_byte_r} + {8'h00, inc0};
  assign split_high = {1'b0, timer_zero_high_byte_r} + {8'h00, split_inc};

  // Unit one overflow is claimed by the split high timer while unit zero is split
  assign ov0 = split ? split_low[8] : step0[16];
  assign ov1 = split ? split_high[8] : step1[16];

  // Bus decode
  assign addr_ok = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0);
  assign wdat = hwdata[7:0];
  assign wr_ctl = wr_pend_r & (wr_idx_r == IDX_RUN_FLAGS);

  // Address phase is latched so that the write lands at the end of its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel & htrans[HTRANS_ACTIVE_BIT] & hwrite & addr_ok;
      wr_idx_r <= haddr[9:2];
    end
  end

  // Read data comes from the address phase, so a write still in flight is not seen
  always_comb begin
    rd_nxt = 8'h00;
    case (haddr[9:2])
      IDX_RUN_FLAGS: begin
        rd_nxt[ONE_FLAG_BIT] = unit_one_overflow_flag;
        rd_nxt[ONE_RUN_BIT] = unit_one_run_r;
        rd_nxt[ZERO_FLAG_BIT] = unit_zero_overflow_flag;
        rd_nxt[ZERO_RUN_BIT] = unit_zero_run_r;
      end
      IDX_MODE: rd_nxt = timer_mode_control_r;
      IDX_ZERO_LOW: rd_nxt = timer_zero_low_byte_r;
      IDX_ONE_LOW: rd_nxt = timer_one_low_byte_r;
      IDX_ZERO_HIGH: rd_nxt = timer_zero_high_byte_r;
      IDX_ONE_HIGH: rd_nxt = timer_one_high_byte_r;
      IDX_TICK_SEL: begin
        rd_nxt[ONE_TICK_BIT] = unit_one_tick_select_r;
        rd_nxt[ZERO_TICK_BIT] = unit_zero_tick_select_r;
      end
      default: rd_nxt = 8'h00;
    endcase
  end

  // Zero wait states; unmapped reads return zero, unmapped writes vanish
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready & hsel & htrans[HTRANS_ACTIVE_BIT] & ~hwrite) begin
        hrdata <= {24'h000000, addr_ok ? rd_nxt : 8'h00};
      end
    end
  end

  // Configuration registers
  // Run bits share a word with the flags; the flags live in their own block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_mode_control_r <= BYTE_RESET;
      unit_zero_tick_select_r <= 1'b0;
      unit_one_tick_select_r <= 1'b0;
      unit_zero_run_r <= 1'b0;
      unit_one_run_r <= 1'b0;
    end else if (wr_pend_r) begin
      if (wr_idx_r == IDX_MODE) begin
        timer_mode_control_r <= wdat;
      end
      if (wr_idx_r == IDX_TICK_SEL) begin
        unit_one_tick_select_r <= wdat[ONE_TICK_BIT];
        unit_zero_tick_select_r <= wdat[ZERO_TICK_BIT];
      end
      if (wr_ctl) begin
        unit_one_run_r <= wdat[ONE_RUN_BIT];
        unit_zero_run_r <= wdat[ZERO_RUN_BIT];
      end
    end
  end

  // Unit zero counter; a software write wins over a count in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_zero_low_byte_r <= BYTE_RESET;
      timer_zero_high_byte_r <= BYTE_RESET;
    end else begin
      if (wr_pend_r & (wr_idx_r == IDX_ZERO_LOW)) begin
        timer_zero_low_byte_r <= wdat;
      end else begin
        timer_zero_low_byte_r <= split ? split_low[7:0] : step0[7:0];
      end
      if (wr_pend_r & (wr_idx_r == IDX_ZERO_HIGH)) begin
        timer_zero_high_byte_r <= wdat;
      end else begin
        timer_zero_high_byte_r <= split ? split_high[7:0] : step0[15:8];
      end
    end
  end

  // Unit one counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_one_low_byte_r <= BYTE_RESET;
      timer_one_high_byte_r <= BYTE_RESET;
    end else begin
      if (wr_pend_r & (wr_idx_r == IDX_ONE_LOW)) begin
        timer_one_low_byte_r <= wdat;
      end else begin
        timer_one_low_byte_r <= step1[7:0];
      end
      if (wr_pend_r & (wr_idx_r == IDX_ONE_HIGH)) begin
        timer_one_high_byte_r <= wdat;
      end else begin
        timer_one_high_byte_r <= step1[15:8];
      end
    end
  end

  // Overflow flags: hardware set beats software write and service clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_zero_overflow_flag <= 1'b0;
      unit_one_overflow_flag <= 1'b0;
    end else begin
      if (ov0) begin
        unit_zero_overflow_flag <= 1'b1;
      end else if (wr_ctl) begin
        unit_zero_overflow_flag <= wdat[ZERO_FLAG_BIT];
      end else if (isr_ack_zero) begin
        unit_zero_overflow_flag <= 1'b0;
      end
      if (ov1) begin
        unit_one_overflow_flag <= 1'b1;
      end else if (wr_ctl) begin
        unit_one_overflow_flag <= wdat[ONE_FLAG_BIT];
      end else if (isr_ack_one) begin
        unit_one_overflow_flag <= 1'b0;
      end
    end
  end
endmodule

// [timer_chk.sv]
/* Checker on the timer block's top ports.
   Assumes one hclk domain; bound onto dual_timer_counter below. */
`timescale 1ns/100ps
module timer_chk (
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Flags
  input wire logic isr_ack_zero,
  input wire logic isr_ack_one,
  input wire logic unit_zero_overflow_flag,
  input wire logic unit_one_overflow_flag
);
  logic rd;
  logic wr;
  logic [7:0] idx;
  assign rd = hsel & hready & htrans[1] & ~hwrite;
  assign wr = hsel & hready & htrans[1] & hwrite;
  assign idx = haddr[9:2];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout == 1'b1) else $error("stall");
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("upper bits");
  a_rdata_holds: assert property (!rd |=> $stable(hrdata)) else $error("rdata moved");
  a_unmapped_zero: assert property (
    rd && (idx < 8'h88 || idx > 8'h8E) |=> hrdata == 32'h0) else $error("unmapped data");
  a_tick_reserved: assert property (
    rd && idx == 8'h8E |=> hrdata[7:5] == 3'h0 && hrdata[2:0] == 3'h0)
    else $error("reserved bits");
  // A flag may only drop after a write data phase or a service acknowledge
  a_flag_zero_clear: assert property (
    $fell(unit_zero_overflow_flag) |-> $past(isr_ack_zero) || $past(wr && idx == 8'h88, 2))
    else $error("flag zero dropped");
  a_flag_one_clear: assert property (
    $fell(unit_one_overflow_flag) |-> $past(isr_ack_one) || $past(wr && idx == 8'h88, 2))
    else $error("flag one dropped");
endmodule

bind dual_timer_counter timer_chk u_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .isr_ack_zero, .isr_ack_one, .unit_zero_overflow_flag, .unit_one_overflow_flag
);

// [ext_pins.sv]
/* Far-side pin model: two count pins and two gating pins.
   Assumes hclk from the bench; its tasks are called just after a rising edge. */
`timescale 1ns/100ps
module ext_pins (
  // Clock
  input wire logic hclk,
  // Pins
  output logic unit_zero_count_pin,
  output logic unit_one_count_pin,
  output logic ext_irq_zero_pin,
  output logic ext_irq_one_pin
);
  logic [1:0] cnt_r = 2'h3;
  logic [1:0] gate_r = 2'h0;
  assign unit_zero_count_pin = cnt_r[0];
  assign unit_one_count_pin = cnt_r[1];
  assign ext_irq_zero_pin = gate_r[0];
  assign ext_irq_one_pin = gate_r[1];
  // Four clocks each way, so no edge slips past the synchroniser
  task automatic fall_pulse(input int u);
    cnt_r[u] <= 1'b0;
    repeat (4) @(posedge hclk);
    cnt_r[u] <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask
  task automatic set_gate(input int u, input logic v);
    gate_r[u] <= v;
    repeat (4) @(posedge hclk);
  endtask
endmodule

// [tb.sv]
/* Bench for the dual timer/counter: bus tasks and one task per scenario.
   Assumes timer_chk binds itself; hready is looped back from hreadyout. */
`timescale 1ns/100ps
module tb
  import timer_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, isr_ack_zero, isr_ack_one;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic unit_zero_count_pin, unit_one_count_pin, ext_irq_zero_pin, ext_irq_one_pin;
  logic unit_zero_overflow_flag, unit_one_overflow_flag;
  int n_mismatch;
  int total_checks;
  ext_pins pins (.hclk, .unit_zero_count_pin, .unit_one_count_pin, .ext_irq_zero_pin,
    .ext_irq_one_pin);
  dual_timer_counter dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .unit_zero_count_pin,
    .unit_one_count_pin, .ext_irq_zero_pin, .ext_irq_one_pin, .isr_ack_zero, .isr_ack_one,
    .unit_zero_overflow_flag, .unit_one_overflow_flag);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("%0d checks, %0d mismatches", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Bounded wait on an edge; a hang counts as a mismatch
  task automatic wait_on(input int f);
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while ((f ? unit_one_overflow_flag : hreadyout) !== 1'b1 && k < 200);
    if (k >= 200) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
      output logic [7:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {22'h0, idx, 2'h0};
    wait_on(0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_on(0);
    rd = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    xfer(1'b1, idx, d, x);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] x;
    xfer(1'b0, idx, 8'h00, x);
    check(x, exp);
  endtask
  // Flags sampled mid-cycle, clear of the edge that updates them
  task automatic flg_chk(input logic [7:0] exp);
    @(negedge hclk);
    check({6'h0, unit_one_overflow_flag, unit_zero_overflow_flag}, exp);
    @(posedge hclk);
  endtask
  task automatic test_regs();
    for (int i = 8'h88; i < 8'h8F; i++) begin
      rd_chk(8'(i), BYTE_RESET);
    end
    wr(IDX_MODE, 8'hA5);
    rd_chk(IDX_MODE, 8'hA5);
    wr(IDX_TICK_SEL, 8'hFF);
    rd_chk(IDX_TICK_SEL, 8'h18);
    rd_chk(8'h90, 8'h00);
    wr(IDX_RUN_FLAGS, 8'hA0);
    flg_chk(8'h03);
    isr_ack_zero <= 1'b1;
    @(posedge hclk);
    isr_ack_zero <= 1'b0;
    flg_chk(8'h02);
    isr_ack_one <= 1'b1;
    @(posedge hclk);
    isr_ack_one <= 1'b0;
    flg_chk(8'h00);
    $display("done regs");
  endtask
  task automatic test_rate();
    logic [7:0] v, e;
    for (int u = 0; u < 2; u++) begin
      for (int s = 0; s < 2; s++) begin
        wr(IDX_MODE, 8'h11);
        wr(IDX_TICK_SEL, s ? 8'(8'h08 << u) : 8'(8'h10 >> u));
        wr(8'(IDX_ZERO_LOW + u), 8'h00);
        wr(IDX_RUN_FLAGS, u ? 8'h40 : 8'h10);
        // Run spans 120 clocks, a whole number of slow and of fast ticks
        repeat (118) @(posedge hclk);
        wr(IDX_RUN_FLAGS, 8'h00);
        xfer(1'b0, 8'(IDX_ZERO_LOW + u), 8'h00, v);
        e = s ? 8'h1E : 8'h0A;
        check(v, e);
      end
    end
    $display("done rate");
  endtask
  task automatic test_pins();
    logic [7:0] lo;
    for (int u = 0; u < 2; u++) begin
      lo = 8'(IDX_ZERO_LOW + u);
      wr(IDX_MODE, 8'(8'h0D << (4 * u)));
      wr(lo, 8'h00);
      wr(IDX_RUN_FLAGS, u ? 8'h40 : 8'h10);
      repeat (3) pins.fall_pulse(u);
      rd_chk(lo, 8'h00);
      pins.set_gate(u, 1'b1);
      repeat (3) pins.fall_pulse(u);
      rd_chk(lo, 8'h03);
      pins.set_gate(u, 1'b0);
    end
    $display("done pins");
  endtask
  task automatic test_modes();
    wr(IDX_MODE, 8'h64);
    wr(IDX_ZERO_LOW, 8'hFF);
    wr(IDX_ZERO_HIGH, 8'hFF);
    wr(IDX_ONE_HIGH, 8'hA5);
    wr(IDX_ONE_LOW, 8'hFE);
    wr(IDX_RUN_FLAGS, 8'h50);
    pins.fall_pulse(0);
    pins.fall_pulse(1);
    flg_chk(8'h01);
    pins.fall_pulse(0);
    pins.fall_pulse(1);
    flg_chk(8'h03);
    rd_chk(IDX_ZERO_LOW, 8'hE1);
    rd_chk(IDX_ZERO_HIGH, 8'h00);
    rd_chk(IDX_ONE_LOW, 8'hA5);
    // Split mode: high timer on unit one's run and tick, low byte on pins
    wr(IDX_MODE, 8'h37);
    wr(IDX_ONE_LOW, 8'h07);
    wr(IDX_ZERO_LOW, 8'h00);
    wr(IDX_TICK_SEL, 8'h10);
    // Preset just before the flag clear, so no wrap slips in ahead of it
    wr(IDX_ZERO_HIGH, 8'hFE);
    wr(IDX_RUN_FLAGS, 8'h40);
    wait_on(1);
    flg_chk(8'h02);
    wr(IDX_RUN_FLAGS, 8'h10);
    pins.fall_pulse(0);
    rd_chk(IDX_ZERO_LOW, 8'h01);
    rd_chk(IDX_ONE_LOW, 8'h07);
    $display("done modes");
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    isr_ack_zero = 1'b0;
    isr_ack_one = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_regs();
    test_rate();
    test_pins();
    test_modes();
    end_of_test();
  end
endmodule
